// file: rtl/dpods_pkg.sv
// Constants, types and register map of the PIO-out / DMA-in command sequencer.
// Assumes one 10 MHz clock domain; every user of it imports the whole package.
// Notes on behaviour
// RULE1: PIO write command, or another block still needed, enters receive preparation.
// RULE2: Receive preparation moves to the setup-frame state once a block can be taken.
// RULE3: All blocks received or abort: receive preparation goes to status sending.
// RULE4: Setup frame initial status: busy zero, data-request one.
// RULE5: Setup frame interrupt flag zero on first block, one on later blocks.
// RULE6: Setup frame ending status: busy one, data-request zero.
// RULE7: Every setup frame carries the byte count of the coming block.
// RULE8: After the setup frame is sent, accept the data frame from transport.
// RULE9: After the data frame arrives, return to receive preparation.
// RULE10: PIO status: register frame with command contents and interrupt flag one.
// RULE11: PIO status error bit 7 may flag an earlier CRC error in this command.
// RULE12: After the status frame is sent, return to idle in either protocol.
// RULE13: DMA read command, or more frames needed, enters data preparation.
// RULE14: DMA preparation moves to data sending once frame data is ready.
// RULE15: All read data sent or abort: DMA preparation goes to status state.
// RULE16: Data sending asks for one frame of at most 2048 doublewords.
// RULE17: After each outgoing data frame, return to DMA preparation.
// RULE18: DMA status: register frame with command contents and interrupt flag one.
// RULE19: Host sends one data frame, no longer than announced, per setup frame.
package dpods_pkg;
	// APB byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FMAX = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_REMAIN = 8'h0C;
	localparam logic [7:0] ADDR_CMDS = 8'h10;
	// Control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CRC_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h3;
	// Frame size limit in doublewords
	localparam int FMAX_W = 12;
	localparam logic [FMAX_W-1:0] FMAX_DW = 12'h800;
	// Status register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_STATE_W = 3;
	localparam int ST_FIRST_BIT = 4;
	localparam int ST_CRC_BIT = 5;
	localparam int ST_DMA_BIT = 6;
	// Frame status flags, bit 1 busy, bit 0 data-request
	localparam logic [1:0] FL_NONE = 2'h0;
	localparam logic [1:0] FL_SETUP_INIT = 2'h1;
	localparam logic [1:0] FL_SETUP_END = 2'h2;
	localparam int ERR_CRC_BIT = 7;
	// Widths
	localparam int DW_W = 24;
	localparam int BLK_W = 16;
	localparam logic [DW_W-1:0] DW_ONE = 24'h000001;
	localparam logic [BLK_W-1:0] BLK_ONE = 16'h0001;
	localparam logic [FMAX_W-1:0] LEN_ONE = 12'h001;
	localparam int FIFO_W = 33;
	localparam int FIFO_D = 32;
	// Frame kinds requested from the transport layer
	typedef enum logic [1:0] {FK_NONE, FK_REG, FK_SETUP, FK_DATA} dpods_kind_e;
	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE, S_PO_PREP, S_PO_SETUP, S_PO_RECV, S_PO_STAT,
		S_DI_PREP, S_DI_SEND, S_DI_STAT
	} dpods_state_e;
endpackage : dpods_pkg

// file: rtl/dpods_strm_if.sv
// Valid/ready stream carrier between the sequencer and its FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface dpods_strm_if #(parameter int W = 33);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	// Producer and consumer views
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : dpods_strm_if

// file: rtl/dpods_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset empties it.
`timescale 1ns/10ps
module dpods_fifo #(
	parameter int W = 33,
	parameter int D = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Fill and drain sides
	dpods_strm_if.snk in_s,
	dpods_strm_if.src out_s
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic full, empty, push, pop;

	// Honest flags from the extra pointer bit
	assign empty = (wr_r == rd_r);
	assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
	assign in_s.ready = !full;
	assign out_s.valid = !empty;
	assign out_s.data = mem[rd_r[AW-1:0]];
	assign push = in_s.valid && !full;
	assign pop = out_s.ready && !empty;

	// Pointer advance
	always_comb begin
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
	end

	// Pointer registers and storage
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
		if (push) begin
			mem[wr_r[AW-1:0]] <= in_s.data;
		end
	end
endmodule : dpods_fifo

// file: rtl/dpods_seq.sv
// Device command-layer sequencer: PIO data-out and DMA data-in protocols.
// Assumes command decoder, transport layer and media on this clock; APB slave.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
module dpods_seq
	import dpods_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Command decoder
	input wire logic i_cmd_valid,
	input wire logic i_cmd_dma_rd,
	input wire logic [BLK_W-1:0] i_cmd_blocks,
	input wire logic [BLK_W-1:0] i_cmd_blk_bytes,
	input wire logic [DW_W-1:0] i_cmd_dwords,
	input wire logic i_abort,
	input wire logic [7:0] i_stat_status,
	input wire logic [7:0] i_stat_error,
	output logic o_cmd_ready,
	// Transport frame requests
	output logic o_tx_req,
	output dpods_kind_e o_tx_kind,
	output logic o_tx_ibit,
	output logic [1:0] o_tx_init_flags,
	output logic [1:0] o_tx_end_flags,
	output logic [BLK_W-1:0] o_tx_count,
	output logic [7:0] o_tx_status,
	output logic [7:0] o_tx_error,
	input wire logic i_tx_done,
	input wire logic i_tx_crc_err,
	// Transport receive stream
	input wire logic i_rx_valid,
	input wire logic [31:0] i_rx_data,
	input wire logic i_rx_last,
	output logic o_rx_ready,
	// Transport transmit stream
	output logic o_txd_valid,
	output logic [31:0] o_txd_data,
	output logic o_txd_last,
	input wire logic i_txd_ready,
	// Media read source
	input wire logic i_src_valid,
	input wire logic [31:0] i_src_data,
	output logic o_src_ready,
	// Media write sink
	output logic o_sink_valid,
	output logic [31:0] o_sink_data,
	output logic o_sink_last,
	input wire logic i_sink_ready
);
	dpods_state_e state_r, state_nxt;
	logic mode_dma_r, mode_dma_nxt;
	logic first_r, first_nxt;
	logic crc_r, crc_nxt;
	logic [BLK_W-1:0] blk_left_r, blk_left_nxt;
	logic [BLK_W-1:0] blk_bytes_r, blk_bytes_nxt;
	logic [DW_W-1:0] dw_left_r, dw_left_nxt;
	logic [FMAX_W-1:0] len_r, len_nxt;
	logic [FMAX_W-1:0] pushed_r, pushed_nxt;
	logic [1:0] ctrl_r, ctrl_nxt;
	logic [FMAX_W-1:0] fmax_r, fmax_nxt;
	logic [31:0] cmds_r, cmds_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic slverr_r, slverr_nxt;
	logic tx_req_nxt, ibit_nxt;
	dpods_kind_e kind_nxt;
	logic [1:0] init_nxt, end_nxt;
	logic [BLK_W-1:0] count_nxt;
	logic [7:0] status_nxt, error_nxt;
	logic cmd_take, push, in_last, fifo_room, fifo_idle;
	logic [31:0] rd_word;
	logic apb_wr, apb_setup, hit;

	dpods_strm_if #(.W(FIFO_W)) fin ();
	dpods_strm_if #(.W(FIFO_W)) fout ();

	// One buffer serves both directions; mode picks its ends
	dpods_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.in_s(fin),
		.out_s(fout)
	);

	// Fill side: host data in PIO receive, media data in DMA send
	always_comb begin
		fin.valid = 1'b0;
		in_last = 1'b0;
		if (state_r == S_PO_RECV) begin
			fin.valid = i_rx_valid; // RULE8
			in_last = i_rx_last;
		end else if (state_r == S_DI_SEND) begin
			fin.valid = i_src_valid && (pushed_r != len_r); // RULE16
			in_last = (pushed_r == len_r - LEN_ONE);
		end
		fin.data = {in_last, (mode_dma_r ? i_src_data : i_rx_data)};
	end
	assign fifo_room = fin.ready;
	assign push = fin.valid && fifo_room;
	assign o_rx_ready = (state_r == S_PO_RECV) && fifo_room;
	assign o_src_ready = (state_r == S_DI_SEND) && (pushed_r != len_r) && fifo_room;

	// Drain side, steered by the latched mode
	assign fifo_idle = !fout.valid;
	assign fout.ready = mode_dma_r ? i_txd_ready : i_sink_ready;
	assign o_txd_valid = fout.valid && mode_dma_r;
	assign o_sink_valid = fout.valid && !mode_dma_r;
	assign o_txd_data = fout.data[31:0];
	assign o_sink_data = fout.data[31:0];
	assign o_txd_last = fout.data[FIFO_W-1];
	assign o_sink_last = fout.data[FIFO_W-1];

	assign o_cmd_ready = (state_r == S_IDLE) && ctrl_r[CTRL_EN_BIT];
	assign cmd_take = o_cmd_ready && i_cmd_valid;

	// Sequencer next state and counters
	always_comb begin
		state_nxt = state_r;
		mode_dma_nxt = mode_dma_r;
		first_nxt = first_r;
		crc_nxt = crc_r;
		blk_left_nxt = blk_left_r;
		blk_bytes_nxt = blk_bytes_r;
		dw_left_nxt = dw_left_r;
		len_nxt = len_r;
		pushed_nxt = pushed_r;
		cmds_nxt = cmds_r;
		// A CRC report in the clearing cycle still counts
		if (state_r != S_IDLE && i_tx_crc_err) begin
			crc_nxt = 1'b1; // RULE11
		end
		unique case (state_r)
			S_IDLE: begin
				if (cmd_take) begin
					mode_dma_nxt = i_cmd_dma_rd;
					first_nxt = 1'b1;
					crc_nxt = i_tx_crc_err;
					blk_left_nxt = i_cmd_blocks;
					blk_bytes_nxt = i_cmd_blk_bytes;
					dw_left_nxt = i_cmd_dwords;
					state_nxt = i_cmd_dma_rd ? S_DI_PREP : S_PO_PREP; // RULE1 RULE13
				end
			end
			S_PO_PREP: begin
				// Drained buffer first: keeps blocks apart, status after media write
				if (fifo_idle && (i_abort || blk_left_r == '0)) begin
					state_nxt = S_PO_STAT; // RULE3
				end else if (fifo_idle) begin
					state_nxt = S_PO_SETUP; // RULE2
				end
			end
			S_PO_SETUP: begin
				if (i_tx_done) begin
					first_nxt = 1'b0;
					state_nxt = S_PO_RECV; // RULE8
				end
			end
			S_PO_RECV: begin
				// Last beat of the single announced frame ends the block
				if (push && in_last) begin
					blk_left_nxt = blk_left_r - BLK_ONE; // RULE19
					state_nxt = S_PO_PREP; // RULE9
				end
			end
			S_DI_PREP: begin
				if (i_abort || dw_left_r == '0) begin
					state_nxt = S_DI_STAT; // RULE15
				end else if (i_src_valid) begin
					pushed_nxt = '0;
					if (dw_left_r < {{(DW_W-FMAX_W){1'b0}}, fmax_r}) begin
						len_nxt = dw_left_r[FMAX_W-1:0];
					end else begin
						len_nxt = fmax_r; // RULE16
					end
					state_nxt = S_DI_SEND; // RULE14
				end
			end
			S_DI_SEND: begin
				if (push) begin
					pushed_nxt = pushed_r + LEN_ONE;
					dw_left_nxt = dw_left_r - DW_ONE;
				end
				if (i_tx_done) begin
					state_nxt = S_DI_PREP; // RULE17
				end
			end
			S_PO_STAT, S_DI_STAT: begin
				if (i_tx_done) begin
					cmds_nxt = cmds_r + 32'h00000001;
					state_nxt = S_IDLE; // RULE12
				end
			end
		endcase
	end

	// Frame request, computed for the coming state so it is held in flops
	always_comb begin
		tx_req_nxt = 1'b0;
		kind_nxt = FK_NONE;
		ibit_nxt = 1'b0;
		init_nxt = FL_NONE;
		end_nxt = FL_NONE;
		count_nxt = '0;
		status_nxt = 8'h00;
		error_nxt = 8'h00;
		unique case (state_nxt)
			S_PO_SETUP: begin
				tx_req_nxt = 1'b1;
				kind_nxt = FK_SETUP;
				init_nxt = FL_SETUP_INIT; // RULE4
				end_nxt = FL_SETUP_END; // RULE6
				ibit_nxt = !first_nxt; // RULE5
				count_nxt = blk_bytes_nxt; // RULE7
			end
			S_DI_SEND: begin
				tx_req_nxt = 1'b1;
				kind_nxt = FK_DATA;
				count_nxt = {2'b00, len_nxt, 2'b00}; // RULE16
			end
			S_PO_STAT, S_DI_STAT: begin
				tx_req_nxt = 1'b1;
				kind_nxt = FK_REG;
				ibit_nxt = 1'b1; // RULE10 RULE18
				status_nxt = i_stat_status;
				error_nxt = i_stat_error;
				if (state_nxt == S_PO_STAT && crc_nxt && ctrl_r[CTRL_CRC_BIT]) begin
					error_nxt[ERR_CRC_BIT] = 1'b1; // RULE11
				end
			end
			default: begin
				tx_req_nxt = 1'b0;
			end
		endcase
	end

	// Sequencer and request registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r <= S_IDLE;
			mode_dma_r <= 1'b0;
			first_r <= 1'b0;
			crc_r <= 1'b0;
			blk_left_r <= '0;
			blk_bytes_r <= '0;
			dw_left_r <= '0;
			len_r <= '0;
			pushed_r <= '0;
			cmds_r <= '0;
			o_tx_req <= 1'b0;
			o_tx_kind <= FK_NONE;
			o_tx_ibit <= 1'b0;
			o_tx_init_flags <= FL_NONE;
			o_tx_end_flags <= FL_NONE;
			o_tx_count <= '0;
			o_tx_status <= 8'h00;
			o_tx_error <= 8'h00;
		end else begin
			state_r <= state_nxt;
			mode_dma_r <= mode_dma_nxt;
			first_r <= first_nxt;
			crc_r <= crc_nxt;
			blk_left_r <= blk_left_nxt;
			blk_bytes_r <= blk_bytes_nxt;
			dw_left_r <= dw_left_nxt;
			len_r <= len_nxt;
			pushed_r <= pushed_nxt;
			cmds_r <= cmds_nxt;
			o_tx_req <= tx_req_nxt;
			o_tx_kind <= kind_nxt;
			o_tx_ibit <= ibit_nxt;
			o_tx_init_flags <= init_nxt;
			o_tx_end_flags <= end_nxt;
			o_tx_count <= count_nxt;
			o_tx_status <= status_nxt;
			o_tx_error <= error_nxt;
		end
	end

	// APB decode: read data latched in setup, so no wait states
	assign apb_setup = i_psel && !i_penable;
	assign apb_wr = i_psel && i_penable && i_pwrite;
	assign o_pready = i_psel && i_penable;
	assign o_prdata = prdata_r;
	assign o_pslverr = slverr_r && o_pready;

	// Register read mux and hit detection
	always_comb begin
		rd_word = 32'h00000000;
		hit = 1'b1;
		unique case (i_paddr)
			ADDR_CTRL: rd_word[1:0] = ctrl_r;
			ADDR_FMAX: rd_word[FMAX_W-1:0] = fmax_r;
			ADDR_STAT: begin
				rd_word[ST_STATE_LSB +: ST_STATE_W] = state_r;
				rd_word[ST_FIRST_BIT] = first_r;
				rd_word[ST_CRC_BIT] = crc_r;
				rd_word[ST_DMA_BIT] = mode_dma_r;
			end
			ADDR_REMAIN: begin
				rd_word[DW_W-1:0] = mode_dma_r ? dw_left_r : {8'h00, blk_left_r};
			end
			ADDR_CMDS: rd_word = cmds_r;
			default: hit = 1'b0;
		endcase
	end

	// Register writes; an out-of-range frame limit falls back to the maximum
	always_comb begin
		ctrl_nxt = ctrl_r;
		fmax_nxt = fmax_r;
		prdata_nxt = prdata_r;
		slverr_nxt = slverr_r;
		if (apb_setup) begin
			prdata_nxt = i_pwrite ? 32'h00000000 : rd_word;
			slverr_nxt = !hit;
		end
		if (apb_wr && i_paddr == ADDR_CTRL) begin
			ctrl_nxt = i_pwdata[1:0];
		end
		if (apb_wr && i_paddr == ADDR_FMAX) begin
			if (i_pwdata[FMAX_W-1:0] == '0 || i_pwdata[FMAX_W-1:0] > FMAX_DW) begin
				fmax_nxt = FMAX_DW; // RULE16
			end else begin
				fmax_nxt = i_pwdata[FMAX_W-1:0];
			end
		end
	end

	// Register file flops
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctrl_r <= CTRL_RST;
			fmax_r <= FMAX_DW;
			prdata_r <= 32'h00000000;
			slverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			fmax_r <= fmax_nxt;
			prdata_r <= prdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end
endmodule : dpods_seq

// file: tb/dpods_props.sv
// Checker of frame requests and command handshake at the sequencer's ports.
// Assumes binding into dpods_seq; it sees those ports only.
`timescale 1ns/10ps
module dpods_props
	import dpods_pkg::*;
(
	// Clock, reset and command
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_dma_rd,
	input wire logic [BLK_W-1:0] i_cmd_blocks,
	input wire logic [BLK_W-1:0] i_cmd_blk_bytes,
	input wire logic i_abort,
	input wire logic o_cmd_ready,
	// Frames and receive stream
	input wire logic o_tx_req,
	input wire dpods_kind_e o_tx_kind,
	input wire logic o_tx_ibit,
	input wire logic [1:0] o_tx_init_flags,
	input wire logic [1:0] o_tx_end_flags,
	input wire logic [BLK_W-1:0] o_tx_count,
	input wire logic i_tx_done,
	input wire logic i_rx_valid,
	input wire logic i_rx_last,
	input wire logic o_rx_ready
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	logic take, setup, seen_r, seen_nxt;
	logic [BLK_W-1:0] bytes_r, bytes_nxt;
	assign take = i_cmd_valid && o_cmd_ready;
	assign setup = o_tx_req && o_tx_kind == FK_SETUP;
	// Block size of the command, and whether a setup frame already went out
	always_comb begin
		seen_nxt = i_rst_n && !take && (seen_r || (setup && i_tx_done));
		bytes_nxt = take ? i_cmd_blk_bytes : bytes_r;
	end
	always_ff @(posedge i_clk) begin
		seen_r <= seen_nxt;
		bytes_r <= bytes_nxt;
	end
	sequence s_pio_take;
		take && !i_cmd_dma_rd && i_cmd_blocks != 16'h0000 && !i_abort;
	endsequence
	sequence s_blk_end;
		i_rx_valid && o_rx_ready && i_rx_last;
	endsequence
	property p_first_ibit;
		s_pio_take |-> ##2 (setup && !o_tx_ibit);
	endproperty
	property p_later_ibit;
		setup && seen_r |-> o_tx_ibit;
	endproperty
	property p_setup_flags;
		setup |-> o_tx_init_flags == FL_SETUP_INIT && o_tx_end_flags == FL_SETUP_END;
	endproperty
	property p_setup_count;
		setup |-> o_tx_count == bytes_r;
	endproperty
	property p_setup_recv;
		setup && i_tx_done |=> !o_tx_req && o_rx_ready;
	endproperty
	property p_blk_end;
		s_blk_end |-> ##[1:60] o_tx_req;
	endproperty
	property p_stat_ibit;
		o_tx_req && o_tx_kind == FK_REG |-> o_tx_ibit;
	endproperty
	property p_data_len;
		o_tx_req && o_tx_kind == FK_DATA |-> o_tx_count != 16'h0000 && o_tx_count <= 16'h2000;
	endproperty
	property p_stat_idle;
		o_tx_req && o_tx_kind == FK_REG && i_tx_done |=> !o_tx_req && o_cmd_ready;
	endproperty
	property p_cmd_take;
		take |=> !o_cmd_ready;
	endproperty
	a_first_ibit: assert property (p_first_ibit) else $error("first setup ibit");
	a_later_ibit: assert property (p_later_ibit) else $error("later setup ibit");
	a_setup_flags: assert property (p_setup_flags) else $error("setup flags");
	a_setup_count: assert property (p_setup_count) else $error("setup count");
	a_setup_recv: assert property (p_setup_recv) else $error("no receive");
	a_blk_end: assert property (p_blk_end) else $error("no frame after block");
	a_stat_ibit: assert property (p_stat_ibit) else $error("status ibit");
	a_data_len: assert property (p_data_len) else $error("data frame size");
	a_stat_idle: assert property (p_stat_idle) else $error("not idle");
	a_cmd_take: assert property (p_cmd_take) else $error("command not taken");
endmodule : dpods_props

bind dpods_seq dpods_props dpods_props_i (
	.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_dma_rd, .i_cmd_blocks, .i_cmd_blk_bytes,
	.i_abort, .o_cmd_ready, .o_tx_req, .o_tx_kind, .o_tx_ibit, .o_tx_init_flags,
	.o_tx_end_flags, .o_tx_count, .i_tx_done, .i_rx_valid, .i_rx_last, .o_rx_ready
);

// file: tb/dpods_xport.sv
// Transport and host model: answers frame requests, sends host blocks, drains data.
// Assumes the sequencer's clock; one frame is handled at a time.
`timescale 1ns/10ps
module dpods_xport
	import dpods_pkg::*;
(
	// Clock and fault control
	input wire logic i_clk,
	input wire logic i_crc_on,
	// Frame requests
	input wire logic i_req,
	input wire dpods_kind_e i_kind,
	input wire logic [BLK_W-1:0] i_count,
	output logic o_done,
	output logic o_crc_err,
	// Host data in, device data out
	output logic o_rx_valid,
	output logic [31:0] o_rx_data,
	output logic o_rx_last,
	input wire logic i_rx_ready,
	input wire logic i_txd_valid,
	input wire logic i_txd_last,
	output logic o_txd_ready
);
	dpods_kind_e k;
	int n;
	// Random delays before each answer, so slow replies are seen too
	initial begin
		o_done = 1'h0;
		o_crc_err = 1'h0;
		o_rx_valid = 1'h0;
		o_rx_data = 32'h0;
		o_rx_last = 1'h0;
		o_txd_ready = 1'h0;
		forever begin
			@(posedge i_clk);
			if (i_req) begin
				k = i_kind;
				n = i_count / 4;
				// A data frame is sent only once its last word is drained
				while (k == FK_DATA && !(i_txd_valid && o_txd_ready && i_txd_last)) begin
					o_txd_ready <= 1'($urandom_range(1));
					@(posedge i_clk);
				end
				o_txd_ready <= 1'h0;
				repeat ($urandom_range(2)) @(posedge i_clk);
				o_done <= 1'h1;
				o_crc_err <= i_crc_on;
				@(posedge i_clk);
				o_done <= 1'h0;
				o_crc_err <= 1'h0;
				// One host frame per setup frame, of the announced size
				for (int b = 0; b < n && k == FK_SETUP; b++) begin
					o_rx_valid <= 1'h1;
					o_rx_data <= $urandom();
					o_rx_last <= b == n - 1;
					do @(posedge i_clk); while (!i_rx_ready);
				end
				o_rx_valid <= 1'h0;
				o_rx_data <= ~o_rx_data; // Released lines never keep the last word
			end
		end
	end
endmodule : dpods_xport

// file: tb/dpods_seq_test.sv
// Self-checking bench: APB registers, PIO write and DMA read commands.
// Assumes dpods_xport as transport; the bench plays decoder and media.
`timescale 1ns/10ps
module dpods_seq_test;
	import dpods_pkg::*;
	// Design ports, named as at the sequencer
	logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
	logic [7:0] i_paddr, i_stat_status, i_stat_error, o_tx_status, o_tx_error;
	logic [31:0] i_pwdata, o_prdata, i_rx_data, o_txd_data, i_src_data, o_sink_data;
	logic i_cmd_valid, i_cmd_dma_rd, i_abort, o_cmd_ready, o_tx_req, o_tx_ibit;
	logic [BLK_W-1:0] i_cmd_blocks, i_cmd_blk_bytes, o_tx_count;
	logic [DW_W-1:0] i_cmd_dwords;
	logic [1:0] o_tx_init_flags, o_tx_end_flags;
	dpods_kind_e o_tx_kind;
	logic i_tx_done, i_tx_crc_err, i_rx_valid, i_rx_last, o_rx_ready;
	logic o_txd_valid, o_txd_last, i_txd_ready, i_src_valid, o_src_ready;
	logic o_sink_valid, o_sink_last, i_sink_ready, crc_on, req_q;
	// Model queues: expected frames, media words, host words
	logic [31:0] fq[$], srcq[$], rxq[$];
	int n_checks, n_mismatch, fmax, dl;
	logic [31:0] fx;
	logic lq[$];
	dpods_seq dpods_seq_i (.*);
	dpods_xport dpods_xport_i (.i_clk(i_clk), .i_crc_on(crc_on), .i_req(o_tx_req),
		.i_kind(o_tx_kind), .i_count(o_tx_count), .o_done(i_tx_done),
		.o_crc_err(i_tx_crc_err), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
		.o_rx_last(i_rx_last), .i_rx_ready(o_rx_ready), .i_txd_valid(o_txd_valid),
		.i_txd_last(o_txd_last), .o_txd_ready(i_txd_ready));
	// 10 MHz clock
	initial begin
		i_clk = 1'h0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		n_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask : chk
	// Frame word: kind, ibit, setup flags, then count or status contents
	function automatic logic [31:0] ef(dpods_kind_e k, logic ib, logic [15:0] v);
		return {k, ib, k == FK_SETUP ? {FL_SETUP_INIT, FL_SETUP_END} : 4'h0, 9'h000, v};
	endfunction : ef
	function automatic logic [31:0] frm();
		logic [3:0] f;
		logic [15:0] v;
		f = {o_tx_init_flags, o_tx_end_flags};
		v = o_tx_kind == FK_REG ? {o_tx_status, o_tx_error} : o_tx_count;
		return {o_tx_kind, o_tx_ibit, f, 9'h000, v};
	endfunction : frm
	// Media source and sink with random stalls; data and frame checks
	always @(posedge i_clk) begin
		if (i_src_valid && o_src_ready) srcq.push_back(i_src_data);
		if (!i_src_valid || o_src_ready) begin
			i_src_valid <= 1'($urandom_range(1));
			i_src_data <= $urandom();
		end
		if (o_txd_valid && i_txd_ready) begin
			dl--;
			chk(o_txd_data, srcq.pop_front(), "out data");
			chk(32'(o_txd_last), 32'(dl == 0), "out last");
		end
		if (i_rx_valid && o_rx_ready) begin
			rxq.push_back(i_rx_data);
			lq.push_back(i_rx_last);
		end
		if (o_sink_valid && i_sink_ready) begin
			chk(o_sink_data, rxq.pop_front(), "sink");
			chk(32'(o_sink_last), 32'(lq.pop_front()), "sink last");
		end
		i_sink_ready <= 1'($urandom_range(1));
		if (o_tx_req && !req_q) begin
			fx = fq.pop_front();
			chk(frm(), fx, "frame");
			if (fx[31:30] == FK_DATA) dl = fx[15:0] / 4;
		end
		req_q <= o_tx_req;
	end
	// One APB transfer; the idle edge at the end keeps transfers apart
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] xd, input logic xe);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		i_penable <= 1'h0;
		@(posedge i_clk);
		i_penable <= 1'h1;
		do @(posedge i_clk); while (!o_pready);
		if (!w) chk(o_prdata, xd, "read");
		chk(o_pslverr, xe, "slave error");
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		@(posedge i_clk);
	endtask : apb
	// One command; the model lists the frames it must produce
	task automatic run(input logic d, input logic [15:0] b, input logic [15:0] y,
		input logic [23:0] w, input logic a, input logic c);
		logic [7:0] s;
		logic [7:0] e;
		int left;
		int n;
		s = 8'($urandom());
		e = 8'($urandom()) & 8'h7F;
		for (int i = 0; i < b && !a && !d; i++) fq.push_back(ef(FK_SETUP, i != 0, y));
		left = a ? 0 : w;
		while (d && left > 0) begin
			n = left < fmax ? left : fmax;
			fq.push_back(ef(FK_DATA, 1'h0, 16'(n * 4)));
			left -= n;
		end
		fq.push_back(ef(FK_REG, 1'h1, {s, e | (c ? 8'h80 : 8'h00)}));
		i_cmd_dma_rd <= d;
		i_cmd_blocks <= b;
		i_cmd_blk_bytes <= y;
		i_cmd_dwords <= w;
		i_abort <= a;
		crc_on <= c;
		i_stat_status <= s;
		i_stat_error <= e;
		i_cmd_valid <= 1'h1;
		do @(posedge i_clk); while (!o_cmd_ready);
		i_cmd_valid <= 1'h0;
		for (int t = 0; t < 30000 && !(fq.size() == 0 && o_cmd_ready); t++) @(posedge i_clk);
		chk(fq.size(), 32'h0, "frames left");
		chk(32'(o_cmd_ready), 32'h1, "not idle");
		i_abort <= 1'h0;
		crc_on <= 1'h0;
		@(posedge i_clk);
	endtask : run
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge i_clk);
		n_mismatch++;
		close_out();
	end
	// Main sequence
	initial begin
		void'($urandom(32'hAE4E));
		{i_rst_n, i_psel, i_penable, i_pwrite, i_cmd_valid, i_cmd_dma_rd, i_abort} = 7'h00;
		{i_paddr, i_pwdata, i_stat_status, i_stat_error} = 56'h0;
		{i_cmd_blocks, i_cmd_blk_bytes, i_cmd_dwords} = 56'h0;
		{i_src_valid, i_src_data, i_sink_ready, crc_on, req_q} = 36'h0;
		fmax = 2048;
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'h1;
		@(posedge i_clk);
		apb(1'h0, ADDR_CTRL, 32'h0, {30'h0, CTRL_RST}, 1'h0);
		apb(1'h0, ADDR_FMAX, 32'h0, 32'h800, 1'h0);
		apb(1'h1, ADDR_STAT, 32'hFF, 32'h0, 1'h0);
		apb(1'h0, ADDR_STAT, 32'h0, 32'h0, 1'h0);
		apb(1'h1, 8'h14, 32'h1, 32'h0, 1'h1);
		apb(1'h0, 8'h14, 32'h0, 32'h0, 1'h1);
		run(1'h0, 16'h3, 16'(4 * $urandom_range(8, 1)), 24'h0, 1'h0, 1'h0);
		run(1'h0, 16'h2, 16'h20, 24'h0, 1'h0, 1'h1);
		run(1'h0, 16'h2, 16'h8, 24'h0, 1'h1, 1'h0);
		run(1'h1, 16'h0, 16'h0, 24'h801, 1'h0, 1'h0);
		apb(1'h0, ADDR_CMDS, 32'h0, 32'h4, 1'h0);
		apb(1'h0, ADDR_REMAIN, 32'h0, 32'h0, 1'h0);
		apb(1'h1, ADDR_FMAX, 32'hFFF, 32'h0, 1'h0);
		apb(1'h0, ADDR_FMAX, 32'h0, 32'h800, 1'h0);
		apb(1'h1, ADDR_FMAX, 32'h10, 32'h0, 1'h0);
		apb(1'h0, ADDR_FMAX, 32'h0, 32'h10, 1'h0);
		fmax = 16;
		repeat (3) run(1'h1, 16'h0, 16'h0, 24'($urandom_range(40, 1)), 1'h0, 1'h0);
		run(1'h1, 16'h0, 16'h0, 24'h5, 1'h1, 1'h0);
		close_out();
	end
endmodule : dpods_seq_test
